// ==== rtl/ces_consts.svh ====
`ifndef CES_CONSTS_SVH
`define CES_CONSTS_SVH
// ==========================================
// header log offsets on the management port
`define CES_HDR_HIGH_ADDR 12'h81c
`define CES_HDR_UMID_ADDR 12'h820
`define CES_HDR_LMID_ADDR 12'h824
`define CES_HDR_LOW_ADDR 12'h828
// ==========================================
// error vector bit positions
`define CES_BIT_TMO_COR 0
`define CES_BIT_TMO_UNC 1
`define CES_BIT_CA 2
`define CES_BIT_UC 3
`define CES_BIT_UR_P 4
`define CES_BIT_UR_NP 5
`define CES_BIT_LOG 6
// ==========================================
// timing
`define CES_REPORT_GAP 4'h8
`define CES_TIMEOUT_MS 50
`define CES_CLK_MHZ 100
`endif

// ==== rtl/ces_lmi_writer.sv ====
`timescale 1ns/1ps
`include "ces_consts.svh"
// ==========================================
// writes four header dwords over the management port
module ces_lmi_writer (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic [127:0] header,
  output logic done,
  // management port
  output logic [11:0] lmi_addr,
  output logic [31:0] lmi_din,
  output logic lmi_wren,
  input wire logic lmi_ack
);
  logic [2:0] idx_r, idx_nxt; // dword index, 0 to 3, high dword first
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;
  logic [11:0] addr_r, addr_nxt;
  logic [31:0] din_r, din_nxt;
  logic wren_r, wren_nxt;

  // address per dword, high dword first
  function automatic logic [11:0] dw_addr(input logic [2:0] i);
    case (i)
      3'h0: dw_addr = `CES_HDR_HIGH_ADDR;
      3'h1: dw_addr = `CES_HDR_UMID_ADDR;
      3'h2: dw_addr = `CES_HDR_LMID_ADDR;
      default: dw_addr = `CES_HDR_LOW_ADDR;
    endcase
  endfunction : dw_addr

  function automatic logic [31:0] dw_data(input logic [127:0] h, input logic [2:0] i);
    case (i)
      3'h0: dw_data = h[127:96];
      3'h1: dw_data = h[95:64];
      3'h2: dw_data = h[63:32];
      default: dw_data = h[31:0];
    endcase
  endfunction : dw_data

  // ==========================================
  // sequencing; each dword waits for its ack
  always_comb begin
    idx_nxt = idx_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    addr_nxt = addr_r;
    din_nxt = din_r;
    wren_nxt = 1'b0;
    if (!busy_r) begin
      if (start) begin
        busy_nxt = 1'b1;
        idx_nxt = 3'h0;
        addr_nxt = dw_addr(3'h0);
        din_nxt = dw_data(header, 3'h0);
        wren_nxt = 1'b1;
      end
    end else if (lmi_ack) begin
      if (idx_r == 3'h3) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        idx_nxt = idx_r + 3'h1;
        addr_nxt = dw_addr(idx_r + 3'h1);
        din_nxt = dw_data(header, idx_r + 3'h1);
        wren_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      idx_r <= 3'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      addr_r <= 12'h000;
      din_r <= 32'h0000_0000;
      wren_r <= 1'b0;
    end else begin
      idx_r <= idx_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      addr_r <= addr_nxt;
      din_r <= din_nxt;
      wren_r <= wren_nxt;
    end
  end

  assign done = done_r;
  assign lmi_addr = addr_r;
  assign lmi_din = din_r;
  assign lmi_wren = wren_r;
endmodule : ces_lmi_writer

// ==== rtl/ces_pkg.sv ====
package ces_pkg;
  // controller states
  typedef enum logic [4:0] {
    CES_IDLE = 5'h01,
    CES_LMI = 5'h02,
    CES_WAIT = 5'h04,
    CES_PULSE = 5'h08,
    CES_GAP = 5'h10
  } ces_state_t;
endpackage : ces_pkg

// ==== rtl/ces_reporter.sv ====
`timescale 1ns/1ps
`include "ces_consts.svh"
// What this block does
// - each error bit pulses one cycle only
// - correctable timeout reports bit zero
// - uncorrectable timeout reports bit one
// - completer abort reported after CA completion
// - unexpected completion reports bit three
// - posted unsupported request reports bit four
// - non-posted UR reports bit five after completion
// - log bit accompanies bits two to five
// - header written via management before log
// - at most one report per eight cycles
// - function number driven with the pulse
// - per-function pending level while awaiting
// - user still sends completions with status
module ces_reporter
  import ces_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // user error requests, one-cycle strobe with data
  input wire logic req_valid,
  input wire logic [5:0] req_kind,
  input wire logic [2:0] req_func,
  input wire logic req_log,
  input wire logic [127:0] req_header,
  input wire logic cpl_sent,
  output logic req_ready,
  // user pending levels
  input wire logic [7:0] user_pending,
  // core sideband
  output logic [6:0] cpl_err,
  output logic [2:0] cpl_err_func,
  output logic [7:0] cpl_pending,
  // core management port
  output logic [11:0] lmi_addr,
  output logic [31:0] lmi_din,
  output logic lmi_wren,
  input wire logic lmi_ack
);
  // 50 ms timeout as cycles, kept for users timing requests
  localparam int unsigned TIMEOUT_CYC = `CES_TIMEOUT_MS * `CES_CLK_MHZ * 1000;

  ces_state_t state_r, state_nxt;
  logic [5:0] kind_r, kind_nxt; // latched error kind
  logic [2:0] func_r, func_nxt; // latched function
  logic log_r, log_nxt; // header log wanted
  logic cpl_ok_r, cpl_ok_nxt; // completion already sent
  logic [127:0] hdr_r, hdr_nxt; // latched header
  logic [3:0] gap_r, gap_nxt; // spacing counter
  logic [6:0] err_r, err_nxt; // error vector toward the core
  logic [2:0] efunc_r, efunc_nxt; // function shown with the vector
  logic [7:0] pend_r, pend_nxt; // registered pending levels
  logic rdy_r, rdy_nxt; // ready toward the user
  logic started_r, started_nxt; // header writer already kicked off
  logic [2:0] acks_r, acks_nxt; // header acks seen, read by the checks only
  logic lmi_start; // one-cycle kick for the header writer
  logic lmi_done; // all four header dwords acknowledged

  // which kinds may carry a logged header
  function automatic logic loggable(input logic [5:0] k);
    loggable = |k[`CES_BIT_UR_NP:`CES_BIT_CA];
  endfunction : loggable

  // which kinds need the completion sent first
  function automatic logic needs_cpl(input logic [5:0] k);
    needs_cpl = k[`CES_BIT_CA] | k[`CES_BIT_UR_NP];
  endfunction : needs_cpl

  // ==========================================
  // header writer
  ces_lmi_writer u_lmi (
    .clock(clock),
    .rst(rst),
    .start(lmi_start),
    .header(hdr_r),
    .done(lmi_done),
    .lmi_addr(lmi_addr),
    .lmi_din(lmi_din),
    .lmi_wren(lmi_wren),
    .lmi_ack(lmi_ack)
  );

  // own latch, so completion news arriving meanwhile is never lost
  assign lmi_start = (state_r == CES_LMI) && !started_r;

  // ==========================================
  // report sequencer
  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    func_nxt = func_r;
    log_nxt = log_r;
    cpl_ok_nxt = cpl_ok_r | cpl_sent;
    hdr_nxt = hdr_r;
    gap_nxt = (gap_r != 4'h0) ? gap_r - 4'h1 : 4'h0;
    err_nxt = 7'h00;
    efunc_nxt = efunc_r;
    rdy_nxt = 1'b0;
    started_nxt = started_r;
    case (state_r)
      CES_IDLE: begin
        rdy_nxt = (gap_r <= 4'h1);
        if (req_valid && rdy_r) begin
          kind_nxt = req_kind;
          func_nxt = req_func;
          log_nxt = req_log && loggable(req_kind);
          hdr_nxt = req_header;
          cpl_ok_nxt = cpl_sent || !needs_cpl(req_kind);
          started_nxt = 1'b0;
          rdy_nxt = 1'b0;
          // header must land before the log bit
          state_nxt = (req_log && loggable(req_kind)) ? CES_LMI : CES_WAIT;
        end
      end
      CES_LMI: begin
        // start goes out once; completion news keeps collecting meanwhile
        started_nxt = 1'b1;
        if (lmi_done) begin
          state_nxt = CES_WAIT;
        end
      end
      CES_WAIT: begin
        // abort and non-posted UR wait for their completion
        if (cpl_ok_r && gap_r == 4'h0) begin
          state_nxt = CES_PULSE;
        end
      end
      CES_PULSE: begin
        err_nxt = {log_r, kind_r};
        efunc_nxt = func_r;
        gap_nxt = `CES_REPORT_GAP;
        state_nxt = CES_GAP;
      end
      CES_GAP: begin
        state_nxt = CES_IDLE;
      end
      default: begin
        state_nxt = CES_IDLE;
      end
    endcase
  end

  // pending levels pass straight through a register
  always_comb begin
    pend_nxt = user_pending;
  end

  // ==========================================
  // header ack count, cleared while idle, saturating
  always_comb begin
    acks_nxt = acks_r;
    if (state_r == CES_IDLE) begin
      acks_nxt = 3'h0;
    end else if (lmi_ack && acks_r != 3'h7) begin
      acks_nxt = acks_r + 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= CES_IDLE;
      kind_r <= 6'h00;
      func_r <= 3'h0;
      log_r <= 1'b0;
      cpl_ok_r <= 1'b0;
      hdr_r <= 128'h0;
      gap_r <= 4'h0;
      err_r <= 7'h00;
      efunc_r <= 3'h0;
      pend_r <= 8'h00;
      rdy_r <= 1'b0;
      started_r <= 1'b0;
      acks_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      func_r <= func_nxt;
      log_r <= log_nxt;
      cpl_ok_r <= cpl_ok_nxt;
      hdr_r <= hdr_nxt;
      gap_r <= gap_nxt;
      err_r <= err_nxt;
      efunc_r <= efunc_nxt;
      pend_r <= pend_nxt;
      rdy_r <= rdy_nxt;
      started_r <= started_nxt;
      acks_r <= acks_nxt;
    end
  end

  assign cpl_err = err_r;
  assign cpl_err_func = efunc_r;
  assign cpl_pending = pend_r;
  assign req_ready = rdy_r;

  // ==========================================
  // checks
  a_pulse_one_cycle: assert property (@(posedge clock) disable iff (rst)
    (|cpl_err) |=> (cpl_err == 7'h00)) else $error("error vector held over one cycle");
  a_report_spacing: assert property (@(posedge clock) disable iff (rst)
    (|cpl_err) |=> (cpl_err == 7'h00) [*7]) else $error("reports closer than eight cycles");
  a_log_with_bits: assert property (@(posedge clock) disable iff (rst)
    cpl_err[`CES_BIT_LOG] |-> (|cpl_err[`CES_BIT_UR_NP:`CES_BIT_CA])) else $error("log bit alone");
  a_func_with_pulse: assert property (@(posedge clock) disable iff (rst)
    (state_r == CES_PULSE) |=> (cpl_err_func == $past(func_r))) else $error("function not updated");
  a_pending_follows: assert property (@(posedge clock) disable iff (rst)
    ##1 (cpl_pending == $past(user_pending))) else $error("pending level lost");
  a_header_before_log: assert property (@(posedge clock) disable iff (rst)
    cpl_err[`CES_BIT_LOG] |-> $past(state_r, 3) != CES_IDLE) else $error("log before header");
  a_kind_to_bits: assert property (@(posedge clock) disable iff (rst)
    (state_r == CES_PULSE) |=> (cpl_err[5:0] == $past(kind_r))) else $error("wrong error bits");
  a_cpl_before_ca: assert property (@(posedge clock) disable iff (rst)
    (state_r == CES_PULSE) |-> cpl_ok_r) else $error("abort reported before completion");
  a_wren_in_lmi: assert property (@(posedge clock) disable iff (rst)
    lmi_wren |-> (state_r == CES_LMI)) else $error("header write outside header phase");
  a_header_acked: assert property (@(posedge clock) disable iff (rst)
    cpl_err[`CES_BIT_LOG] |-> (acks_r == 3'h4)) else $error("log bit before four header acks");
  a_ready_held_off: assert property (@(posedge clock) disable iff (rst)
    (|cpl_err) |=> !req_ready [*7]) else $error("ready back inside the report gap");
endmodule : ces_reporter

// ==== verification/ces_core_model.sv ====
`timescale 1ns/1ps
// ==========================================
// core side: header words, lmi acks, error intake
module ces_core_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic slow,
  // management port
  input wire logic [11:0] lmi_addr,
  input wire logic [31:0] lmi_din,
  input wire logic lmi_wren,
  output logic lmi_ack,
  // sideband
  input wire logic [6:0] cpl_err,
  input wire logic [2:0] cpl_err_func
);
  logic [31:0] hdr_r [4]; // write-only header words
  wire [11:0] off = lmi_addr - 12'h81c;
  int ack_cnt_r; // ack delay, slow mode stalls
  int gap_r; // cycles since last report
  int n_rep_r; // reports taken
  int bad_r; // spacing, width or log faults
  logic [6:0] prev_r;
  logic [2:0] func_r; // function of last report
  // one process: acks and intake are independent
  always_ff @(posedge clock) begin
    lmi_ack <= 1'b0;
    prev_r <= cpl_err;
    if (rst) begin
      ack_cnt_r <= 0;
      gap_r <= 8;
      n_rep_r <= 0;
      bad_r <= 0;
    end else begin
      if (lmi_wren) begin
        if (off <= 12'h00c) hdr_r[off[3:2]] <= lmi_din;
        ack_cnt_r <= slow ? 3 : 1;
      end else if (ack_cnt_r != 0) begin
        ack_cnt_r <= ack_cnt_r - 1;
        lmi_ack <= (ack_cnt_r == 1);
      end
      gap_r <= gap_r + 1;
      // each nonzero vector is one event
      if (cpl_err != 7'h00) begin
        n_rep_r <= n_rep_r + 1;
        func_r <= cpl_err_func;
        gap_r <= 1;
        if (gap_r < 8 || prev_r != 7'h00) bad_r <= bad_r + 1;
        if (cpl_err[6] && cpl_err[5:2] == 4'h0) bad_r <= bad_r + 1;
      end
    end
  end
endmodule : ces_core_model

// ==== verification/tb_ces_reporter.sv ====
`timescale 1ns/1ps
// ==========================================
// bench for the error reporter
module tb_ces_reporter;
  logic clock, rst, req_valid, req_log, cpl_sent, req_ready, slow, lmi_wren, lmi_ack;
  logic [5:0] req_kind;
  logic [2:0] req_func, cpl_err_func;
  logic [127:0] req_header;
  logic [7:0] user_pending, cpl_pending;
  logic [6:0] cpl_err;
  logic [11:0] lmi_addr;
  logic [31:0] lmi_din;
  int miscompares, n_checks;
  ces_reporter dut (.clock(clock), .rst(rst), .req_valid(req_valid), .req_kind(req_kind),
    .req_func(req_func), .req_log(req_log), .req_header(req_header), .cpl_sent(cpl_sent),
    .req_ready(req_ready), .user_pending(user_pending), .cpl_err(cpl_err),
    .cpl_err_func(cpl_err_func), .cpl_pending(cpl_pending), .lmi_addr(lmi_addr),
    .lmi_din(lmi_din), .lmi_wren(lmi_wren), .lmi_ack(lmi_ack));
  ces_core_model core (.clock(clock), .rst(rst), .slow(slow), .lmi_addr(lmi_addr),
    .lmi_din(lmi_din), .lmi_wren(lmi_wren), .lmi_ack(lmi_ack), .cpl_err(cpl_err),
    .cpl_err_func(cpl_err_func));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // one report; cdly cycles pass before the user completion goes out
  task automatic report(logic [5:0] kind, logic [2:0] func, logic log, int cdly);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    check("ready", req_ready, 1);
    {req_kind, req_func, req_log, req_valid} = {kind, func, log, 1'b1};
    cpl_sent = (cdly == 0); // completion already out at take
    @(negedge clock);
    {req_valid, cpl_sent} = 2'b00;
    repeat (cdly) @(negedge clock) check("early", cpl_err, 0);
    cpl_sent = (cdly > 0);
    n = 0;
    while (cpl_err === 7'h00 && n < 100) begin
      @(negedge clock);
      cpl_sent = 1'b0;
      n++;
    end
    check("err", cpl_err, {log & |kind[5:2], kind});
    check("func", cpl_err_func, func);
    @(negedge clock);
    cpl_sent = 1'b0;
    check("pulse", cpl_err, 0);
    check("core func", core.func_r, func);
    if (log) for (int j = 0; j < 4; j++) check("hdr", core.hdr_r[j], req_header[127-32*j -: 32]);
  endtask : report
  task automatic t_plain();
    foreach (req_kind[i]) if (i != 2 && i != 5) report(6'h01 << i, 3'(i), 1'b0, 0);
  endtask : t_plain
  task automatic t_logged();
    // fast acks finish the header early, so the abort must wait on its completion
    req_header = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
    report(6'h04, 3'h5, 1'b1, 20);
    slow = 1'b1;
    req_header = ~req_header;
    report(6'h20, 3'h7, 1'b1, 0);
    slow = 1'b0;
    report(6'h08, 3'h2, 1'b1, 0);
  endtask : t_logged
  // request during the spacing gap is dropped
  task automatic t_refuse();
    report(6'h10, 3'h1, 1'b0, 0);
    {req_kind, req_valid} = {6'h02, 1'b1};
    @(negedge clock);
    req_valid = 1'b0;
    repeat (30) @(negedge clock) check("refused", cpl_err, 0);
  endtask : t_refuse
  task automatic t_pending();
    foreach (cpl_pending[i]) begin
      user_pending = 8'ha5 ^ (8'h01 << i);
      repeat (2) @(negedge clock);
      check("pending", cpl_pending, user_pending);
    end
  endtask : t_pending
  initial begin
    {rst, req_valid, req_log, cpl_sent, slow, req_kind, req_func} = {1'b1, 17'h0};
    {user_pending, req_header} = 136'h0;
    repeat (20) @(negedge clock);
    check("rst err", cpl_err, 0);
    check("rst wren", lmi_wren, 0);
    rst = 1'b0;
    t_plain();
    t_logged();
    t_refuse();
    t_pending();
    check("spacing", core.bad_r, 0);
    check("reports", core.n_rep_r, 8);
    results();
  end
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    results();
  end
endmodule : tb_ces_reporter
